// >>> logic/lpm_pkg.sv
// Constants, types and register map of the LCD memory and pin role map.
// Assumes one system clock and a frame tick from the LCD timing logic.
// Functional notes
// - Higher mux modes: one memory byte per pin.
// - Segment capacity 295/348/399/448 with mux commons.
// - Shared pad: 0 digital I/O, 1 LCD.
// - Dedicated LCD pins ignore pad select bits.
// - Role bit 0: pin is segment driver.
// - Role bit 1: memory picks common line 0-7.
// - Role bits reset to 0, all segments.
// - Low mux: low nibble even, high odd.
// - Higher mux: byte holds one pin's common.
// - Low mux commons limited by mux count.
// - Segment pins: memory bits switch segments only.
// - Memory bit 1 visible, 0 invisible.
// - Clear bit zeroes memory at frame boundary.
package lpm_pkg;
    localparam int NUM_PINS  = 64;
    localparam int MEM_BYTES = 64;
    localparam int SEL_BYTES = NUM_PINS / 8;

    localparam logic [7:0] MEM_BASE  = 8'h00;
    localparam logic [7:0] PAD_BASE  = 8'h40;
    localparam logic [7:0] ROLE_BASE = 8'h48;
    localparam logic [7:0] CTRL_ADDR = 8'h50;
    localparam logic [7:0] STAT_ADDR = 8'h51;

    localparam int CTRL_MUX_LSB = 0;
    localparam int CTRL_MUX_W   = 3;
    localparam int CTRL_CLR_BIT = 3;
    localparam int STAT_CLR_BIT = 0;
    localparam int STAT_CAP_BIT = 1;

    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] NIB_ZERO = 8'h00;
    localparam logic [7:0] ALL_LINES = 8'hff;
    localparam int NIB_W = 4;

    // Mux factor minus one; the two halves of the code path split at 5-mux.
    typedef enum logic [2:0] {
        MUX_STATIC = 3'h0,
        MUX_2      = 3'h1,
        MUX_3      = 3'h2,
        MUX_4      = 3'h3,
        MUX_5      = 3'h4,
        MUX_6      = 3'h5,
        MUX_7      = 3'h6,
        MUX_8      = 3'h7
    } lpm_mux_t;

    // Segment capacity per mux mode.
    localparam int unsigned SEG_CAP [8] =
        '{63, 124, 183, 240, 295, 348, 399, 448};

    typedef struct packed {
        logic       lcd_fn;
        logic       is_com;
        logic [7:0] seg_on;
        logic [7:0] com_sel;
    } lpm_pin_t;
endpackage : lpm_pkg

// >>> logic/lpm_pin_decode.sv
// Decodes one LCD pin from its display memory byte and role bits.
// Assumes the caller hands in the byte chosen for the current mux mode.
`timescale 1ns/1ps
module lpm_pin_decode (
    input  wire logic [7:0]       i_mem_byte,
    input  wire logic             i_odd,
    input  wire lpm_pkg::lpm_mux_t i_mux,
    input  wire logic             i_lcd_fn,
    input  wire logic             i_is_com,
    output lpm_pkg::lpm_pin_t     o_pin
);
    logic       wide;
    logic [7:0] data;
    logic [7:0] line_mask;

    always_comb begin
        wide = (i_mux >= lpm_pkg::MUX_5);
        if (wide) begin
            data = i_mem_byte;
        end else if (i_odd) begin
            data = {lpm_pkg::NIB_ZERO[3:0], i_mem_byte[7:4]};
        end else begin
            data = {lpm_pkg::NIB_ZERO[3:0], i_mem_byte[3:0]};
        end
        // Only lines below the mux factor exist in the current mode.
        line_mask = lpm_pkg::ALL_LINES >> (3'h7 - i_mux);
        o_pin.lcd_fn = i_lcd_fn;
        o_pin.is_com = i_is_com;
        if (i_is_com) begin
            o_pin.seg_on  = lpm_pkg::NIB_ZERO;
            o_pin.com_sel = data & line_mask;
        end else begin
            o_pin.seg_on  = data & line_mask;
            o_pin.com_sel = lpm_pkg::NIB_ZERO;
        end
    end
endmodule : lpm_pin_decode

// >>> logic/lpm_role_map.sv
// LCD display memory, pad function and pin role map with register port.
// Assumes a frame tick pulse from the LCD timing logic on i_sys_clk.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module lpm_role_map #(
    parameter int NUM_PINS = lpm_pkg::NUM_PINS,
    parameter logic [NUM_PINS-1:0] DEDICATED_PINS = '0
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic [7:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic                   i_frame_tick,
    output logic [7:0]                  o_rdata,
    output logic [NUM_PINS-1:0]         o_pad_lcd_sel,
    output lpm_pkg::lpm_pin_t [NUM_PINS-1:0] o_pin_map,
    output logic                        o_cap_exceeded
);
    localparam int MEM_BYTES = NUM_PINS;
    localparam int SEL_BYTES = NUM_PINS / 8;
    localparam int CNT_W     = $clog2(NUM_PINS + 1);
    localparam int IDX_W     = $clog2(MEM_BYTES);

    logic [7:0]          mem_r [MEM_BYTES];
    logic [NUM_PINS-1:0] pad_sel_r;
    logic [NUM_PINS-1:0] role_r;
    lpm_pkg::lpm_mux_t   mux_r;
    logic                clr_pend_r;
    logic                clr_now;
    logic                wr_ctrl;
    logic [7:0]          rdata_nxt;
    logic [IDX_W-1:0]    mem_idx;

    lpm_pkg::lpm_pin_t [NUM_PINS-1:0] pin_nxt;
    logic [CNT_W-1:0]    seg_cnt;
    logic [CNT_W-1:0]    seg_cap_pins;
    logic                cap_nxt;

    assign wr_ctrl = i_wr && (i_addr == lpm_pkg::CTRL_ADDR);
    assign clr_now = clr_pend_r && i_frame_tick;
    // Only the low address bits index the memory; range is checked apart.
    assign mem_idx = IDX_W'(i_addr - lpm_pkg::MEM_BASE);

    // Display memory. A software write that lands in the clearing cycle
    // is lost, because the whole memory is zeroed at that edge.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            for (int b = 0; b < MEM_BYTES; b++) begin
                mem_r[b] <= lpm_pkg::BYTE_RST;
            end
        end else if (clr_now) begin
            for (int b = 0; b < MEM_BYTES; b++) begin
                mem_r[b] <= lpm_pkg::BYTE_RST;
            end
        end else if (i_wr && (i_addr >= lpm_pkg::MEM_BASE)
                     && (i_addr < lpm_pkg::MEM_BASE + 8'(MEM_BYTES)))
        begin
            mem_r[mem_idx] <= i_wdata;
        end
    end

    // Clear request flag. A new request in the clearing cycle survives.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            clr_pend_r <= 1'b0;
        end else if (wr_ctrl && i_wdata[lpm_pkg::CTRL_CLR_BIT]) begin
            clr_pend_r <= 1'b1;
        end else if (clr_now) begin
            clr_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            mux_r <= lpm_pkg::MUX_STATIC;
        end else if (wr_ctrl) begin
            mux_r <= lpm_pkg::lpm_mux_t'(
                i_wdata[lpm_pkg::CTRL_MUX_LSB +: lpm_pkg::CTRL_MUX_W]);
        end
    end

    // Pad function and pin role selects, eight pins per byte.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pad_sel_r <= '0;
            role_r    <= '0;
        end else if (i_wr) begin
            for (int s = 0; s < SEL_BYTES; s++) begin
                if (i_addr == lpm_pkg::PAD_BASE + 8'(s)) begin
                    pad_sel_r[8*s +: 8] <= i_wdata;
                end else if (i_addr == lpm_pkg::ROLE_BASE + 8'(s)) begin
                    role_r[8*s +: 8] <= i_wdata;
                end
            end
        end
    end

    // Register readback; unmapped addresses read as zero.
    always_comb begin
        rdata_nxt = lpm_pkg::BYTE_RST;
        if (i_addr < lpm_pkg::MEM_BASE + 8'(MEM_BYTES)) begin
            rdata_nxt = mem_r[mem_idx];
        end else if (i_addr == lpm_pkg::CTRL_ADDR) begin
            rdata_nxt[lpm_pkg::CTRL_MUX_LSB +: lpm_pkg::CTRL_MUX_W] = mux_r;
            rdata_nxt[lpm_pkg::CTRL_CLR_BIT] = clr_pend_r;
        end else if (i_addr == lpm_pkg::STAT_ADDR) begin
            rdata_nxt[lpm_pkg::STAT_CLR_BIT] = clr_pend_r;
            rdata_nxt[lpm_pkg::STAT_CAP_BIT] = o_cap_exceeded;
        end else begin
            for (int s = 0; s < SEL_BYTES; s++) begin
                if (i_addr == lpm_pkg::PAD_BASE + 8'(s)) begin
                    rdata_nxt = pad_sel_r[8*s +: 8];
                end else if (i_addr == lpm_pkg::ROLE_BASE + 8'(s)) begin
                    rdata_nxt = role_r[8*s +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= lpm_pkg::BYTE_RST;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= lpm_pkg::BYTE_RST;
        end
    end

    // Per-pin decode. The memory byte a pin reads depends on the mode:
    // its own byte from 5-mux up, the shared byte below that.
    generate
        for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
            logic [7:0] pin_byte;
            logic       pin_lcd;
            assign pin_byte = (mux_r >= lpm_pkg::MUX_5) ? mem_r[p]
                                                         : mem_r[p / 2];
            // Dedicated pins are LCD pins whatever the pad select says.
            assign pin_lcd = DEDICATED_PINS[p] | pad_sel_r[p];
            lpm_pin_decode u_dec (
                .i_mem_byte (pin_byte),
                .i_odd      (1'(p % 2)),
                .i_mux      (mux_r),
                .i_lcd_fn   (pin_lcd),
                .i_is_com   (role_r[p]),
                .o_pin      (pin_nxt[p])
            );
        end
    endgenerate

    // Segment pin count against what the selected mode can drive.
    always_comb begin
        seg_cnt = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (pin_nxt[p].lcd_fn && !pin_nxt[p].is_com) begin
                seg_cnt = seg_cnt + CNT_W'(1);
            end
        end
        seg_cap_pins = CNT_W'(lpm_pkg::SEG_CAP[mux_r]
                              / (32'(mux_r) + 32'd1));
        cap_nxt = (seg_cnt > seg_cap_pins);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pad_lcd_sel  <= '0;
            o_pin_map      <= '0;
            o_cap_exceeded <= 1'b0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                o_pad_lcd_sel[p] <= pin_nxt[p].lcd_fn;
            end
            o_pin_map      <= pin_nxt;
            o_cap_exceeded <= cap_nxt;
        end
    end
endmodule : lpm_role_map

// >>> test/lpm_role_map_asserts.sv
// Port checker for the LCD memory and pin role map.
// Assumes a bind to lpm_role_map; mode and clear state mirror the writes.
`timescale 1ns/1ps
module lpm_role_map_asserts #(
    parameter int                  NUM_PINS       = lpm_pkg::NUM_PINS,
    parameter logic [NUM_PINS-1:0] DEDICATED_PINS = '0
) (
    input wire logic                             i_sys_clk,
    input wire logic                             i_sys_rst,
    input wire logic [7:0]                       i_addr,
    input wire logic [7:0]                       i_wdata,
    input wire logic                             i_wr,
    input wire logic                             i_rd,
    input wire logic                             i_frame_tick,
    input wire logic [7:0]                       o_rdata,
    input wire logic [NUM_PINS-1:0]              o_pad_lcd_sel,
    input wire lpm_pkg::lpm_pin_t [NUM_PINS-1:0] o_pin_map,
    input wire logic                             o_cap_exceeded
);
    logic [2:0] mode_r;
    logic       pend_r;
    wire [NUM_PINS-1:0] seg_pin;
    wire        ctl_w = i_wr && i_addr == lpm_pkg::CTRL_ADDR;
    wire        pad_w = i_wr && i_addr == lpm_pkg::PAD_BASE;
    wire        rd_st = i_rd && i_addr == lpm_pkg::STAT_ADDR;
    wire        rd_ct = i_rd && i_addr == lpm_pkg::CTRL_ADDR;
    // The mode and pending clear are not visible at the ports, so mirror them.
    always_ff @(posedge i_sys_clk)
        if (i_sys_rst) mode_r <= 3'h0;
        else if (ctl_w) mode_r <= i_wdata[2:0];
    always_ff @(posedge i_sys_clk)
        if (i_sys_rst) pend_r <= 1'b0;
        else if (ctl_w && i_wdata[3]) pend_r <= 1'b1;
        else if (i_frame_tick) pend_r <= 1'b0;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        wire lpm_pkg::lpm_pin_t q = o_pin_map[p];
        assign seg_pin[p] = o_pad_lcd_sel[p] && !q.is_com;
        a_seg_no_com: assert property (!q.is_com |-> q.com_sel == 8'h00)
            else $error("segment pin selects a common line");
        a_com_no_seg: assert property (q.is_com |-> q.seg_on == 8'h00)
            else $error("common pin shows segments");
        a_line_mask: assert property (
            ((q.seg_on | q.com_sel) >> ({1'b0, $past(mode_r)} + 4'h1)) == 8'h00)
            else $error("bit above the mux count");
        a_role_reset: assert property ($fell(i_sys_rst) |-> (!q.is_com) [*3])
            else $error("pin not a segment after reset");
        a_clear_zero: assert property (pend_r && i_frame_tick && !ctl_w
            |-> ##2 {q.seg_on, q.com_sel} == 16'h0000)
            else $error("memory not cleared at frame");
    end
    a_dedicated: assert property (!$past(i_sys_rst) |->
        (o_pad_lcd_sel & DEDICATED_PINS) == DEDICATED_PINS)
        else $error("dedicated pin not LCD");
    a_pad_to_fn: assert property (pad_w ##1 !pad_w |-> ##1
        o_pin_map[0].lcd_fn == $past(i_wdata[0], 2) &&
        o_pad_lcd_sel[0] == $past(i_wdata[0], 2))
        else $error("pad select not applied");
    a_stat_read: assert property (rd_st |=> o_rdata[0] == $past(pend_r))
        else $error("clear pending misread");
    a_mode_read: assert property (rd_ct |=>
        o_rdata[3:0] == {$past(pend_r), $past(mode_r)})
        else $error("control misread");
    a_cap_flag: assert property (o_cap_exceeded ==
        ($countones(seg_pin) > lpm_pkg::SEG_CAP[$past(mode_r)]
                               / ($past(mode_r) + 1)))
        else $error("capacity flag wrong");
    c_clear: cover property (pend_r && i_frame_tick);
    c_mux8: cover property (ctl_w && i_wdata[2:0] == 3'h7);
    c_com: cover property (o_pin_map[4].is_com);
    c_cap: cover property (o_cap_exceeded);
endmodule : lpm_role_map_asserts

// >>> test/lpm_panel_model.sv
// Passive LCD glass: counts the segments that show.
// Assumes the decoded pin map and pad selects of the role map block.
`timescale 1ns/1ps
module lpm_panel_model #(
    parameter int NUM_PINS = 64
) (
    input  wire lpm_pkg::lpm_pin_t [NUM_PINS-1:0] i_pins,
    input  wire logic [NUM_PINS-1:0]              i_lcd_sel,
    output int                                    o_lit
);
    // Glass only sees pins routed to LCD; commons carry no segments.
    always_comb begin
        o_lit = 0;
        for (int p = 0; p < NUM_PINS; p++)
            if (i_lcd_sel[p] && i_pins[p].lcd_fn && !i_pins[p].is_com)
                o_lit += $countones(i_pins[p].seg_on);
    end
endmodule : lpm_panel_model

// >>> test/tb_lpm_role_map.sv
// Self-checking bench for the LCD memory and pin role map.
// Assumes a 10 MHz clock and the register map of the package.
`timescale 1ns/1ps
module tb_lpm_role_map;
    localparam logic [63:0] DED = 64'h8000000000000000;
    localparam logic [7:0]  CT  = lpm_pkg::CTRL_ADDR;
    localparam logic [7:0]  ST  = lpm_pkg::STAT_ADDR;
    localparam logic [7:0]  PB  = lpm_pkg::PAD_BASE;
    logic                     i_sys_clk = 1'b0;
    logic                     i_sys_rst = 1'b1;
    logic [7:0]               i_addr = 8'h00;
    logic [7:0]               i_wdata = 8'h00;
    logic                     i_wr = 1'b0, i_rd = 1'b0, i_frame_tick = 1'b0;
    logic [7:0]               o_rdata;
    logic [63:0]              o_pad_lcd_sel;
    lpm_pkg::lpm_pin_t [63:0] o_pin_map;
    logic                     o_cap_exceeded;
    int                       lit;
    int                       n_fail = 0;
    int                       n_checks = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    lpm_role_map #(.NUM_PINS(64), .DEDICATED_PINS(DED)) uut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_frame_tick(i_frame_tick), .o_rdata(o_rdata),
        .o_pad_lcd_sel(o_pad_lcd_sel), .o_pin_map(o_pin_map),
        .o_cap_exceeded(o_cap_exceeded));
    lpm_panel_model #(.NUM_PINS(64)) u_panel (
        .i_pins(o_pin_map), .i_lcd_sel(o_pad_lcd_sel), .o_lit(lit));
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", o_rdata, e);
    endtask : rd
    // Decode lands one edge after the write edge; two spare edges of margin.
    task settle;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask : settle
    // One frame tick; with w set, the last write is repeated beside it.
    task tick(input logic w);
        @(posedge i_sys_clk);
        i_frame_tick <= 1'b1;
        i_wr <= w;
        @(posedge i_sys_clk);
        i_frame_tick <= 1'b0;
        i_wr <= 1'b0;
    endtask : tick
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        rd(lpm_pkg::ROLE_BASE, 8'h00);
        rd(CT, 8'h00);
        rd(8'h60, 8'h00);
        wr(PB, 8'h06);
        wr(8'h01, 8'hff);
        for (int m = 0; m < 8; m++) begin
            wr(CT, 8'(m));
            settle();
            chk("seg", o_pin_map[m > 3 ? 1 : 2].seg_on, 8'hff >> (7 - m));
            chk("odd", o_pin_map[m > 3 ? 2 : 3].seg_on,
                m > 3 ? 8'h00 : 8'hff >> (7 - m));
            chk("lit", 8'(lit), 8'(m + 1));
        end
        wr(lpm_pkg::ROLE_BASE, 8'h10);
        wr(8'h04, 8'h40);
        settle();
        chk("com8", o_pin_map[4].com_sel, 8'h40);
        chk("seg8", o_pin_map[4].seg_on, 8'h00);
        wr(CT, 8'h03);
        wr(8'h02, 8'h24);
        settle();
        chk("com4", o_pin_map[4].com_sel, 8'h04);
        chk("seg5", o_pin_map[5].seg_on, 8'h02);
        wr(PB, 8'h01);
        settle();
        chk("pad", o_pad_lcd_sel[7:0], 8'h01);
        chk("ded", o_pad_lcd_sel[63:56], 8'h80);
        rd(PB + 8'h07, 8'h00);
        wr(CT, 8'h0f);
        rd(CT, 8'h0f);
        rd(ST, 8'h01);
        tick(1'b0);
        settle();
        chk("clr", o_pin_map[1].seg_on, 8'h00);
        rd(8'h04, 8'h00);
        rd(ST, 8'h00);
        // A clear request in the clearing cycle keeps the request pending.
        wr(8'h01, 8'hff);
        wr(CT, 8'h0f);
        tick(1'b1);
        settle();
        chk("clr2", o_pin_map[1].seg_on, 8'h00);
        rd(ST, 8'h01);
        tick(1'b0);
        rd(ST, 8'h00);
        // All pads LCD with one common pin: 63 segment pins.
        for (int s = 0; s < 8; s++) begin
            wr(PB + 8'(s), 8'hff);
        end
        for (int m = 0; m < 8; m++) begin
            wr(CT, 8'(m));
            settle();
            chk("cap", 8'(o_cap_exceeded), 8'(m > 0));
            rd(ST, m > 0 ? 8'h02 : 8'h00);
        end
        stop_test();
    end
    initial begin
        #1000000;
        n_fail++;
        stop_test();
    end
endmodule : tb_lpm_role_map
bind lpm_role_map lpm_role_map_asserts #(
    .NUM_PINS(NUM_PINS), .DEDICATED_PINS(DEDICATED_PINS)) u_chk (.*);
